// [inc/uart_brg_params.svh]
// Offsets, field positions, reset values and counts of the baud and break control block
`ifndef UART_BRG_PARAMS_SVH
`define UART_BRG_PARAMS_SVH
`define ADDR_MODE 16'hff50
`define ADDR_CLKSEL 16'hff56
`define ADDR_DIVISOR 16'hff57
`define ADDR_BRKCTL 16'hff58
`define RST_MODE 8'h01
`define RST_CLKSEL 4'h0
`define RST_DIVISOR 8'hff
`define RST_BRKCTL 8'h16
`define BIT_POWER 7
`define BIT_TXE 6
`define BIT_RXE 5
`define BIT_RXSTAT 7
`define BIT_RXTRIG 6
`define BIT_TXTRIG 5
`define BIT_DIR 1
`define BIT_INV 0
`define K_MIN 8'h04
`define SEL_EXT 4'hb
`define SEL_MAX_DIV 4'ha
`define BREAK_MIN_BITS 5'h0b
`endif

// [inc/uart_brg_pkg.sv]
// Types shared by the baud and break control block
package uart_brg_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_WAIT_LOW, RX_COUNT} rx_state_e;
  typedef enum logic {TX_IDLE, TX_BREAK} tx_state_e;
endpackage : uart_brg_pkg

// [inc/brg_if.sv]
// Link between the register side and the baud divider
interface brg_if;
  logic [7:0] divisor; // Programmed k
  logic base_tick; // One pulse per base clock period
  logic run; // Transmit or receive enabled
  logic bit_tick; // One pulse per serial bit
  modport gen (input divisor, input base_tick, input run, output bit_tick);
  modport ctrl (output divisor, output base_tick, output run, input bit_tick);
endinterface : brg_if

// [src/baud_divider.sv]
// Eight-bit divider counter and halving stage giving the bit tick
`include "uart_brg_params.svh"
module baud_divider (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic power_n_async,
  brg_if.gen brg
);
  logic [7:0] cnt; // Base clock cycles counted
  logic half; // Halving toggle
  logic pulse; // Counter output pulse
  logic [7:0] eff_k; // Divisor actually used

  // Prohibited small settings are held at the least legal value
  assign eff_k = (brg.divisor < `K_MIN) ? `K_MIN : brg.divisor;

  // Counter restarts at k minus one; a rewrite with the same k changes nothing
  always_ff @(posedge clk or negedge power_n_async) begin
    if (!power_n_async) begin
      cnt <= 8'h00;
      pulse <= 1'b0;
    end else if (!resetn) begin
      cnt <= 8'h00;
      pulse <= 1'b0;
    end else if (clk_en) begin
      pulse <= 1'b0;
      if (!brg.run) begin
        cnt <= 8'h00; // Idle port clears the counter to zero
      end else if (brg.base_tick) begin
        if (cnt >= eff_k - 8'h01) begin
          cnt <= 8'h00;
          pulse <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

  // Every second counter pulse is one bit
  always_ff @(posedge clk or negedge power_n_async) begin
    if (!power_n_async) begin
      half <= 1'b0;
      brg.bit_tick <= 1'b0;
    end else if (!resetn) begin
      half <= 1'b0;
      brg.bit_tick <= 1'b0;
    end else if (clk_en) begin
      brg.bit_tick <= pulse && half;
      if (!brg.run) begin
        half <= 1'b0;
      end else if (pulse) begin
        half <= ~half;
      end
    end
  end

  a_bit_half: assert property (@(posedge clk) disable iff (!resetn || !power_n_async)
    (clk_en && pulse && !half && brg.run) |=> !brg.bit_tick)
    else $error("bit tick on first counter pulse");
  a_div_wrap: assert property (@(posedge clk) disable iff (!resetn || !power_n_async)
    (clk_en && brg.run && brg.base_tick && cnt == eff_k - 8'h01) |=> pulse && cnt == 8'h00)
    else $error("divider did not wrap at k minus one");
endmodule : baud_divider

// [src/uart_baud_and_break_field_ctrl.sv]
// Baud divisor, base clock choice and break field control of an async serial port
`include "uart_brg_params.svh"
module uart_baud_and_break_field_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_base_tick,
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  output logic bit_order_select,
  output logic break_rx_done,
  output logic transmit_complete_interrupt
);
  brg_if brg (); // Divider link

  logic [7:0] serial_mode_register; // Power and enables
  logic [3:0] base_clock_select; // Base clock choice
  logic [7:0] divisor_value; // Divisor k
  logic break_rx_status; // Reception in progress
  logic [2:0] break_length_code; // Sent break length
  logic tx_polarity_invert; // Transmit line inversion
  logic port_power_enable;
  logic transmit_enable;
  logic receive_enable;
  logic power_n_async; // Low clears internals at once
  logic [9:0] prescale; // Free base clock prescaler
  logic [9:0] sel_mask; // Prescaler bits that must be all ones
  logic [4:0] rx_bits; // Low bits counted on the receive line
  logic [4:0] tx_bits; // Break bits sent
  logic [4:0] tx_len; // Break length in bits
  logic wr_mode, wr_clksel, wr_div, wr_brk;
  logic rx_trig, tx_trig;
  logic rx_error; // Low shorter than a break
  uart_brg_pkg::rx_state_e rx_state;
  uart_brg_pkg::tx_state_e tx_state;

  // Mode fields; power low doubles as the asynchronous clear of all engines
  assign port_power_enable = serial_mode_register[`BIT_POWER];
  assign transmit_enable = serial_mode_register[`BIT_TXE];
  assign receive_enable = serial_mode_register[`BIT_RXE];
  assign power_n_async = port_power_enable;
  // Write decodes; unmapped addresses match none and are ignored
  assign wr_mode = reg_wr && reg_addr == `ADDR_MODE;
  assign wr_clksel = reg_wr && reg_addr == `ADDR_CLKSEL;
  assign wr_div = reg_wr && reg_addr == `ADDR_DIVISOR;
  assign wr_brk = reg_wr && reg_addr == `ADDR_BRKCTL;
  // Triggers take effect only with power and the matching enable on
  assign rx_trig = wr_brk && reg_wdata[`BIT_RXTRIG] && port_power_enable && receive_enable;
  assign tx_trig = wr_brk && reg_wdata[`BIT_TXTRIG] && port_power_enable && transmit_enable;
  assign rx_error = rx_state == uart_brg_pkg::RX_COUNT && serial_rx_line
    && rx_bits < `BREAK_MIN_BITS;

  // Length map: 101..111 give 13..15, 000..011 give 16..19, 100 gives 20
  always_comb begin
    if (break_length_code[2] && (break_length_code[1] || break_length_code[0])) begin
      tx_len = 5'd8 + {2'b00, break_length_code};
    end else begin
      tx_len = 5'd16 + {2'b00, break_length_code};
    end
  end

  // Mode and base clock select registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_mode_register <= `RST_MODE;
      base_clock_select <= `RST_CLKSEL;
    end else if (clk_en) begin
      if (wr_mode) begin
        serial_mode_register <= reg_wdata;
      end
      if (wr_clksel) begin
        base_clock_select <= reg_wdata[3:0];
      end
    end
  end

  // Divisor register; software keeps it steady while enabled, refresh is harmless
  always_ff @(posedge clk) begin
    if (!resetn) begin
      divisor_value <= `RST_DIVISOR;
    end else if (clk_en && wr_div) begin
      divisor_value <= reg_wdata;
    end
  end

  // Break control settings; triggers are not stored, they start the engines
  always_ff @(posedge clk) begin
    if (!resetn) begin
      break_length_code <= 3'(`RST_BRKCTL >> 2);
      bit_order_select <= 1'(`RST_BRKCTL >> `BIT_DIR);
      tx_polarity_invert <= 1'(`RST_BRKCTL >> `BIT_INV);
    end else if (clk_en && wr_brk) begin
      break_length_code <= reg_wdata[4:2];
      bit_order_select <= reg_wdata[`BIT_DIR];
      tx_polarity_invert <= reg_wdata[`BIT_INV];
    end
  end

  // Prescaler runs only with power on
  always_ff @(posedge clk or negedge power_n_async) begin
    if (!power_n_async) begin
      prescale <= 10'h000;
    end else if (!resetn) begin
      prescale <= 10'h000;
    end else if (clk_en) begin
      prescale <= prescale + 10'h001;
    end
  end

  // Base tick: division by two to the select power, or the outside timer tick
  assign sel_mask = 10'((11'h001 << base_clock_select) - 11'h001);
  always_comb begin
    if (base_clock_select == `SEL_EXT) begin
      brg.base_tick = ext_base_tick;
    end else if (base_clock_select <= `SEL_MAX_DIV) begin
      brg.base_tick = (prescale & sel_mask) == sel_mask;
    end else begin
      brg.base_tick = 1'b0; // Unused codes stop the divider
    end
  end
  assign brg.divisor = divisor_value;
  assign brg.run = transmit_enable || receive_enable;

  baud_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .power_n_async(power_n_async),
    .brg(brg.gen)
  );

  // Break reception engine
  always_ff @(posedge clk or negedge power_n_async) begin
    if (!power_n_async) begin
      rx_state <= uart_brg_pkg::RX_IDLE;
      rx_bits <= 5'h00;
      break_rx_status <= 1'b0;
      break_rx_done <= 1'b0;
    end else if (!resetn || (clk_en && !receive_enable)) begin
      rx_state <= uart_brg_pkg::RX_IDLE;
      rx_bits <= 5'h00;
      break_rx_status <= 1'b0;
      break_rx_done <= 1'b0;
    end else if (clk_en) begin
      break_rx_done <= 1'b0;
      if (rx_trig) begin
        // A rewrite with the trigger set restarts detection
        rx_state <= uart_brg_pkg::RX_WAIT_LOW;
        rx_bits <= 5'h00;
        break_rx_status <= 1'b1;
      end else begin
        unique case (rx_state)
          uart_brg_pkg::RX_IDLE: begin
            rx_bits <= 5'h00;
          end
          uart_brg_pkg::RX_WAIT_LOW: begin
            rx_bits <= 5'h00;
            if (!serial_rx_line) begin
              rx_state <= uart_brg_pkg::RX_COUNT;
            end
          end
          uart_brg_pkg::RX_COUNT: begin
            if (serial_rx_line) begin
              rx_bits <= 5'h00;
              if (rx_error) begin
                rx_state <= uart_brg_pkg::RX_WAIT_LOW;
              end else begin
                rx_state <= uart_brg_pkg::RX_IDLE;
                break_rx_status <= 1'b0;
                break_rx_done <= 1'b1;
              end
            end else if (brg.bit_tick && rx_bits != 5'h1f) begin
              rx_bits <= rx_bits + 5'h01; // Saturates on very long lows
            end
          end
          // Unused state code falls back to idle rather than hanging
          default: begin
            rx_state <= uart_brg_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // Break transmission engine and line driver
  always_ff @(posedge clk or negedge power_n_async) begin
    if (!power_n_async) begin
      tx_state <= uart_brg_pkg::TX_IDLE;
      tx_bits <= 5'h00;
      serial_tx_line <= 1'b1;
      transmit_complete_interrupt <= 1'b0;
    end else if (!resetn || (clk_en && !transmit_enable)) begin
      tx_state <= uart_brg_pkg::TX_IDLE;
      tx_bits <= 5'h00;
      serial_tx_line <= ~tx_polarity_invert;
      transmit_complete_interrupt <= 1'b0;
    end else if (clk_en) begin
      transmit_complete_interrupt <= 1'b0;
      if (tx_trig) begin
        tx_state <= uart_brg_pkg::TX_BREAK;
        tx_bits <= 5'h00;
        serial_tx_line <= tx_polarity_invert;
      end else begin
        unique case (tx_state)
          uart_brg_pkg::TX_IDLE: begin
            serial_tx_line <= ~tx_polarity_invert;
          end
          uart_brg_pkg::TX_BREAK: begin
            serial_tx_line <= tx_polarity_invert;
            if (brg.bit_tick) begin
              if (tx_bits + 5'h01 >= tx_len) begin
                tx_state <= uart_brg_pkg::TX_IDLE;
                tx_bits <= 5'h00;
                serial_tx_line <= ~tx_polarity_invert;
                transmit_complete_interrupt <= 1'b1;
              end else begin
                tx_bits <= tx_bits + 5'h01;
              end
            end
          end
        endcase
      end
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `ADDR_MODE: reg_rdata <= serial_mode_register;
          `ADDR_CLKSEL: reg_rdata <= {4'h0, base_clock_select};
          `ADDR_DIVISOR: reg_rdata <= divisor_value;
          // Trigger bits always read zero
          `ADDR_BRKCTL: reg_rdata <= {break_rx_status, 2'b00, break_length_code,
            bit_order_select, tx_polarity_invert};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Checks on reset values, trigger reads and both break engines
  a_div_reset: assert property (@(posedge clk)
    (!resetn ##1 resetn) |-> divisor_value == 8'hff)
    else $error("divisor not all ones after reset");
  a_ctl_reset: assert property (@(posedge clk)
    (!resetn ##1 resetn) |-> {break_length_code, bit_order_select, tx_polarity_invert} == 5'h16)
    else $error("break control not 16 hex after reset");
  a_trig_read: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && reg_rd && reg_addr == `ADDR_BRKCTL) |=> reg_rdata[6:5] == 2'b00)
    else $error("trigger bit read as one");
  a_rx_start: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && rx_trig) |=> break_rx_status && rx_state == uart_brg_pkg::RX_WAIT_LOW)
    else $error("reception did not start on trigger");
  a_rx_error: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && receive_enable && rx_error && !rx_trig) |=> break_rx_status
      && rx_state == uart_brg_pkg::RX_WAIT_LOW)
    else $error("reception error did not return to waiting");
  a_power_clear: assert property (@(posedge clk)
    !port_power_enable |-> !break_rx_status && tx_state == uart_brg_pkg::TX_IDLE)
    else $error("internals active with power off");
  a_rxe_clear: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && !receive_enable) |=> !break_rx_status)
    else $error("status kept with reception disabled");
  a_tx_level: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && transmit_enable && tx_state == uart_brg_pkg::TX_BREAK && !brg.bit_tick
      && !wr_brk && !wr_mode) |=> serial_tx_line == tx_polarity_invert)
    else $error("break level wrong for polarity");
  a_tx_length: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && transmit_enable && !tx_trig && tx_state == uart_brg_pkg::TX_BREAK
      && brg.bit_tick && tx_bits + 5'h01 == tx_len) |=> transmit_complete_interrupt)
    else $error("break did not end at its length");
  a_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && break_rx_done) |=> !break_rx_done)
    else $error("break received pulse longer than one cycle");
  a_tx_pulse: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && transmit_complete_interrupt) |=> !transmit_complete_interrupt)
    else $error("break sent pulse longer than one cycle");
endmodule : uart_baud_and_break_field_ctrl

// [verif/serial_node_model.sv]
// Far serial node: idles its line high, sends low periods, measures breaks seen
module serial_node_model (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic inv,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int run; // Cycles the line has held its break level so far
  int last_break; // Length of the last finished break, in clocks
  initial begin
    rx_line = 1'b1;
    run = 0;
    last_break = 0;
  end
  // Break level is the inverse of idle, so a polarity slip shows as a wrong length
  always @(posedge clk) begin
    if (tx_line === inv) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_break <= run;
      run <= 0;
    end
  end
  // Line goes low for n clocks, then back to its pulled-up idle
  task drive_low(input int n);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk);
    rx_line <= 1'b1;
  endtask : drive_low
endmodule : serial_node_model

// [verif/uart_baud_and_break_field_ctrl_bench.sv]
// Register-level bench for the baud divisor and break field control
`include "uart_brg_params.svh"
module uart_baud_and_break_field_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_base_tick = 1'b0;
  logic serial_rx_line;
  logic serial_tx_line;
  logic bit_order_select;
  logic break_rx_done;
  logic transmit_complete_interrupt;
  logic inv = 1'b0; // Polarity the node expects
  int n_mismatch = 0;
  int checks = 0;
  int n_done = 0; // Break received pulses seen
  int cyc = 0;
  int ph = 0;
  logic [7:0] d;
  uart_baud_and_break_field_ctrl DUT (.clk(clk), .resetn(resetn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_base_tick(ext_base_tick), .serial_rx_line(serial_rx_line),
    .serial_tx_line(serial_tx_line), .bit_order_select(bit_order_select),
    .break_rx_done(break_rx_done), .transmit_complete_interrupt(transmit_complete_interrupt));
  serial_node_model node (.clk(clk), .tx_line(serial_tx_line), .inv(inv),
    .rx_line(serial_rx_line));
  // 50 MHz clock
  always #10 clk = ~clk;
  // External tick every third clock, a rate no prescaler code gives
  always @(posedge clk) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    ext_base_tick <= (ph == 2);
    if (break_rx_done === 1'b1) begin
      n_done <= n_done + 1;
    end
  end
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task end_sim();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  function automatic int bits_of(input logic [2:0] c);
    return (c >= 3'h5) ? int'(c) + 8 : ((c == 3'h4) ? 20 : int'(c) + 16);
  endfunction : bits_of
  // One break sent with the given base clock, divisor and length code
  task tx_case(input logic [3:0] sel, input logic [7:0] k, input logic [2:0] code,
    input logic pol, input int unit, input logic refresh);
    int n;
    int p;
    int w;
    logic ok;
    n = bits_of(code);
    p = 2 * int'(k) * unit;
    wr(`ADDR_MODE, 8'h80);
    wr(`ADDR_CLKSEL, {4'h0, sel});
    wr(`ADDR_DIVISOR, k);
    wr(`ADDR_BRKCTL, {3'b000, code, 1'b1, pol});
    inv = pol;
    wr(`ADDR_MODE, 8'hc0);
    repeat (3) @(posedge clk);
    #1;
    chk("tx idle", {7'h00, serial_tx_line}, {7'h00, ~pol});
    wr(`ADDR_BRKCTL, {3'b001, code, 1'b1, pol});
    rd(`ADDR_BRKCTL, d);
    chk("tx trigger", d, {3'b000, code, 1'b1, pol});
    if (refresh) begin
      wr(`ADDR_DIVISOR, k);
      wr(`ADDR_BRKCTL, {3'b000, code, 1'b1, pol});
    end
    w = 0;
    while (transmit_complete_interrupt !== 1'b1 && w < 4000) begin
      @(posedge clk);
      #1;
      w++;
    end
    chk("tx complete", {7'h00, w < 4000}, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    // First bit may be partial, so allow up to one bit short
    ok = node.last_break >= (n - 1) * p && node.last_break <= n * p + 2;
    chk("break length", {7'h00, ok}, 8'h01);
    $display("break sent: code %0d clocks %0d", code, node.last_break);
  endtask : tx_case
  logic [15:0] ra [5] = '{`ADDR_MODE, `ADDR_CLKSEL, `ADDR_DIVISOR, `ADDR_BRKCTL, 16'hff59};
  logic [7:0] rv [5] = '{`RST_MODE, {4'h0, `RST_CLKSEL}, `RST_DIVISOR, `RST_BRKCTL, 8'h00};
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("tx at reset", {7'h00, serial_tx_line}, 8'h01);
    chk("order at reset", {7'h00, bit_order_select}, 8'h01);
    wr(16'hff59, 8'h5a);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk("reset value", d, rv[i]);
    end
    wr(`ADDR_DIVISOR, `K_MIN);
    rd(`ADDR_DIVISOR, d);
    chk("divisor min", d, 8'h04);
    wr(`ADDR_DIVISOR, 8'hff);
    rd(`ADDR_DIVISOR, d);
    chk("divisor max", d, 8'hff);
    wr(`ADDR_BRKCTL, 8'h14);
    @(posedge clk);
    #1;
    chk("msb first", {7'h00, bit_order_select}, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      tx_case(4'h0, 8'h04, c[2:0], 1'b0, 1, c == 0);
    end
    tx_case(4'h1, 8'h05, 3'h5, 1'b1, 2, 1'b0);
    tx_case(`SEL_EXT, 8'h04, 3'h4, 1'b0, 3, 1'b0);
    $display("test break send done");
    wr(`ADDR_MODE, 8'h80);
    wr(`ADDR_CLKSEL, 8'h00);
    wr(`ADDR_DIVISOR, 8'h04);
    wr(`ADDR_BRKCTL, 8'h16);
    inv = 1'b0;
    wr(`ADDR_MODE, 8'ha0);
    wr(`ADDR_BRKCTL, 8'h56);
    rd(`ADDR_BRKCTL, d);
    chk("rx armed", d, 8'h96);
    node.drive_low(40);
    repeat (4) @(posedge clk);
    rd(`ADDR_BRKCTL, d);
    chk("short low", d, 8'h96);
    chk("no done", n_done[7:0], 8'h00);
    node.drive_low(112);
    repeat (4) @(posedge clk);
    chk("done count", n_done[7:0], 8'h01);
    rd(`ADDR_BRKCTL, d);
    chk("rx finished", d, 8'h16);
    wr(`ADDR_BRKCTL, 8'h56);
    wr(`ADDR_MODE, 8'h80);
    rd(`ADDR_BRKCTL, d);
    chk("rx disabled", d, 8'h16);
    wr(`ADDR_MODE, 8'ha0);
    wr(`ADDR_BRKCTL, 8'h56);
    wr(`ADDR_MODE, 8'h00);
    rd(`ADDR_BRKCTL, d);
    chk("power off", d, 8'h16);
    $display("test break receive done");
    end_sim();
  end
endmodule : uart_baud_and_break_field_ctrl_bench
